// File: verilog/rsc_pkg.sv
// package of constants and carriers for the reset and stop recovery control
package rsc_pkg;
   // ------------------------------------------------------------------
   // register map (byte addresses on the wishbone slave)
   // ------------------------------------------------------------------
   localparam logic [3:0] RSC_ADR_CAUSE = 4'h0;
   localparam logic [3:0] RSC_ADR_OSC = 4'h4;
   localparam logic [3:0] RSC_ADR_WDOG = 4'h8;
   localparam logic [3:0] RSC_ADR_STAT = 4'hC;
   // reset values
   localparam logic [7:0] RSC_OSC_RST = 8'hA0;
   localparam logic [7:0] RSC_WDOG_RST = 8'h00;
   // reset_cause_reg field positions
   localparam int RSC_POS_POR = 7;
   localparam int RSC_POS_STOP = 6;
   localparam int RSC_POS_WDOG = 5;
   localparam int RSC_POS_PIN = 4;
   // osc_ctrl_reg clock select field, zero selects the precision osc
   localparam int RSC_POS_CSEL = 0;
   localparam logic [1:0] RSC_CSEL_IPO = 2'h0;
   // reset vector locations in program memory
   localparam logic [15:0] RSC_VEC_HI_ADDR = 16'h0002;
   localparam logic [15:0] RSC_VEC_LO_ADDR = 16'h0003;
   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int RSC_HOLD_SHORT = 66;     // precision osc cycles
   localparam int RSC_HOLD_LONG = 5000;    // precision osc cycles, crystal on
   localparam int RSC_PIN_MIN_CLKS = 4;    // system clocks, run or halt
   localparam int RSC_CLK_PS = 4000;
   localparam int RSC_STOP_GLITCH_PS = 12000;
   localparam int RSC_STOP_MIN_CLKS =
      (RSC_STOP_GLITCH_PS + RSC_CLK_PS - 1) / RSC_CLK_PS;
   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      RSC_KIND_NONE,
      RSC_KIND_SYS,
      RSC_KIND_STOP
   } rsc_kind_t;
   typedef struct packed {
      logic por;
      logic stop;
      logic wdog;
      logic pin;
   } rsc_cause_t;
   typedef struct packed {
      logic xtal_en;         // crystal oscillator enabled
      logic wdog_rst_sel;    // watchdog_reset_select_option
      logic bo_stop_keep;    // brownout_stop_keep_on_option
   } rsc_opt_t;
endpackage : rsc_pkg

// File: verilog/rsc_reset_ctrl.sv
// reset and stop-mode recovery controller with wishbone register access
// How it works
// - system reset on power-on, brownout, watchdog, enabled pin, debugger bit
// - in stop mode, watchdog or enabled pin edge starts recovery
// - core held in reset about 66 precision oscillator cycles
// - crystal option stretches the hold to about 5000 oscillator cycles
// - recovery resets core, only watchdog and osc control registers
// - power-related delay count starts once supply passes power-on level
// - pin still low at count end keeps reset until release
// - at reset all port pins become inputs, pull-ups off, except pd0
// - pd0 acts as open-drain reset line, driven low until the hold count ends
// - core and peripherals idle in reset, oscillators keep running
// - registers with defined reset values reload them on reset
// - on release core fetches vector from 0002H and 0003H
// - after system reset the precision oscillator is the clock
// - pin pulses under four system clocks ignored in run or halt
// - debugger reset resets everything but the debugger block
// - power-on cause flag set after power-on or brownout reset
// - brownout forces reset, held while supply below power-on level
// - option bit decides if brownout stays active in stop mode
// - watchdog resets when option is 1, else raises interrupt
// - watchdog reset sets watchdog cause flag
// - pin-caused system reset sets pin cause flag
// - cause register read-only, read clears its upper four bits
// - any stop recovery sets stop cause flag
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl
   import rsc_pkg::*;
#(
   parameter int NPINS = 8,                       // recovery-capable pins
   parameter int HOLD_SHORT = RSC_HOLD_SHORT,     // osc cycles
   parameter int HOLD_LONG = RSC_HOLD_LONG        // osc cycles, crystal on
)(
   input wire logic i_clk,                        // system clock
   input wire logic i_sys_rst,                    // sync reset, high
   // wishbone slave
   input wire logic i_wb_cyc,                     // cycle
   input wire logic i_wb_stb,                     // strobe
   input wire logic i_wb_we,                      // write enable
   input wire logic [3:0] i_wb_adr,               // byte address
   input wire logic [3:0] i_wb_sel,               // byte lanes
   input wire logic [31:0] i_wb_dat,              // write data
   output logic [31:0] o_wb_dat,                  // read data
   output logic o_wb_ack,                         // acknowledge
   // analog and pin side, asynchronous
   input wire logic i_ipo_clk,                    // precision osc, sampled
   input wire logic i_por_ok,                     // supply above por level
   input wire logic i_brownout_n,                 // brownout_detector, low
   input wire logic i_pd0_in,                     // port_d_bit_zero_pin level
   input wire logic [NPINS-1:0] i_gpio_in,        // port pin levels
   // same-domain inputs
   input wire logic [NPINS-1:0] i_smr_en,         // pins enabled for recovery
   input wire logic i_pd0_rst_en,                 // pin reset function on
   input wire logic i_stop_mode,                  // core is in stop mode
   input wire logic i_wdog_timeout,               // watchdog time-out pulse
   input wire logic i_dbg_rst_req,                // debugger_control_reg bit0
   input wire logic i_debug_pin_low,              // debug_pin break seen
   input wire rsc_opt_t i_opt,                    // nonvolatile options
   // outputs
   output logic o_core_rst,                       // core held in reset
   output logic o_periph_rst,                     // registers to reset value
   output logic o_gpio_rst,                       // pins input, pull-ups off
   output logic o_pd0_out,                        // pd0 drive level
   output logic o_pd0_oe,                         // pd0 open-drain enable
   output logic o_dbg_rst_clr,                    // clear debugger reset bit
   output logic o_wdog_irq,                       // watchdog interrupt pulse
   output logic o_vec_fetch,                      // start vector fetch
   output logic [15:0] o_vec_hi_addr,             // vector high byte addr
   output logic [15:0] o_vec_lo_addr,             // vector low byte addr
   output logic [1:0] o_clk_sel,                  // system clock select
   output logic [7:0] o_wdog_ctrl                 // watchdog_ctrl_reg
);
   // ------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------
   localparam int NSYNC = NPINS + 4;
   logic [NSYNC-1:0] sync1_r, sync2_r;
   logic [NPINS-1:0] gpio_prev_r;
   logic ipo_prev_r;
   logic ipo_s, por_s, bo_n_s, pd0_s, ipo_tick;
   logic [NPINS-1:0] gpio_s;

   always_ff @(posedge i_clk)
   begin
      sync1_r <= {i_gpio_in, i_ipo_clk, i_por_ok, i_brownout_n, i_pd0_in};
      sync2_r <= sync1_r;
   end

   assign {gpio_s, ipo_s, por_s, bo_n_s, pd0_s} = sync2_r;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         ipo_prev_r <= 1'b0;
         // start from the pin levels so reset gives no false transition
         gpio_prev_r <= gpio_s;
      end
      else
      begin
         ipo_prev_r <= ipo_s;
         gpio_prev_r <= gpio_s;
      end
   end

   // one tick per rising edge of the precision oscillator
   assign ipo_tick = ipo_s & ~ipo_prev_r;

   // ------------------------------------------------------------------
   // reset pin glitch filter
   // ------------------------------------------------------------------
   // the pin must stay low a whole window; shorter pulses are dropped
   logic [2:0] pin_low_cnt_r;
   logic pin_low_cnt_hit;
   logic [2:0] pin_min;
   logic in_rst;

   assign pin_min = i_stop_mode ? 3'(RSC_STOP_MIN_CLKS) :
                                  3'(RSC_PIN_MIN_CLKS);

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         pin_low_cnt_r <= '0;
      // our own low drive during reset must not count as a pin request
      else if (pd0_s || !i_pd0_rst_en || in_rst)
         pin_low_cnt_r <= '0;
      else if (pin_low_cnt_r != pin_min)
         pin_low_cnt_r <= pin_low_cnt_r + 3'h1;
   end

   assign pin_low_cnt_hit = (pin_low_cnt_r == pin_min);

   // ------------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------------
   logic bo_active, por_req, wdog_sys, sys_req, stop_req, smr_edge;

   // brownout counts in stop mode only when the option keeps it on
   assign bo_active = ~bo_n_s & (~i_stop_mode | i_opt.bo_stop_keep);
   assign por_req = ~por_s | bo_active;
   assign wdog_sys = i_wdog_timeout & i_opt.wdog_rst_sel;
   assign smr_edge = |((gpio_s ^ gpio_prev_r) & i_smr_en);
   assign sys_req = por_req | pin_low_cnt_hit | i_dbg_rst_req |
                    (wdog_sys & ~i_stop_mode) |
                    (i_debug_pin_low & i_stop_mode);
   assign stop_req = i_stop_mode & (i_wdog_timeout | smr_edge);

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN,
      ST_SUPPLY,
      ST_HOLD,
      ST_PIN
   } rsc_state_t;

   rsc_state_t state_r;
   rsc_kind_t kind_r;
   logic [12:0] hold_cnt_r;
   logic [12:0] hold_lim;
   logic release_now;
   rsc_cause_t pend_r;

   function automatic logic [12:0] hold_limit(input logic xtal);
      hold_limit = xtal ? 13'(HOLD_LONG) : 13'(HOLD_SHORT);
   endfunction : hold_limit

   assign hold_lim = hold_limit(i_opt.xtal_en);

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         state_r <= ST_SUPPLY;
      else
      begin
         unique case (state_r)
            ST_RUN:
               if (por_req)
                  state_r <= ST_SUPPLY;
               else if (sys_req || stop_req)
                  state_r <= ST_HOLD;
            ST_SUPPLY:
               if (!por_req)
                  state_r <= ST_HOLD;
            ST_HOLD:
               if (por_req)
                  state_r <= ST_SUPPLY;
               else if (hold_cnt_r >= hold_lim)
                  state_r <= ST_PIN;
            ST_PIN:
               if (por_req)
                  state_r <= ST_SUPPLY;
               else if (pd0_s)
                  state_r <= ST_RUN;
         endcase
      end
   end

   // the hold counter only advances on oscillator ticks
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || state_r != ST_HOLD)
         hold_cnt_r <= '0;
      else if (ipo_tick && hold_cnt_r < hold_lim)
         hold_cnt_r <= hold_cnt_r + 13'h1;
   end

   // a system request during a stop hold upgrades it to a system reset
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         kind_r <= RSC_KIND_SYS;
      else if (state_r == ST_RUN && !por_req && !sys_req && stop_req)
         kind_r <= RSC_KIND_STOP;
      else if (por_req || sys_req)
         kind_r <= RSC_KIND_SYS;
      else if (state_r == ST_RUN)
         kind_r <= RSC_KIND_NONE;
   end

   // causes gathered while the reset is held, published at release
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         pend_r <= '{por: 1'b1, default: 1'b0};
      else if (release_now)
         pend_r <= '0;
      else
      begin
         if (por_req || i_dbg_rst_req || (i_debug_pin_low && i_stop_mode))
            pend_r.por <= 1'b1;
         if (stop_req)
            pend_r.stop <= 1'b1;
         if (i_wdog_timeout && (i_opt.wdog_rst_sel || i_stop_mode))
            pend_r.wdog <= 1'b1;
         if (pin_low_cnt_hit)
            pend_r.pin <= 1'b1;
      end
   end

   assign in_rst = (state_r != ST_RUN);
   // the pin is let go after the count, so only an outside driver keeps it low
   assign release_now = in_rst && !por_req && state_r == ST_PIN && pd0_s;

   // ------------------------------------------------------------------
   // reset outputs from flip-flops so release is clean, pd0 drive level tied low
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_core_rst <= 1'b1;
         o_periph_rst <= 1'b1;
         o_gpio_rst <= 1'b1;
         o_pd0_oe <= 1'b1;
         o_vec_fetch <= 1'b0;
         o_dbg_rst_clr <= 1'b0;
      end
      else
      begin
         // the oscillators are outside this block and never stopped here
         o_core_rst <= in_rst && !release_now;
         o_periph_rst <= in_rst && !release_now &&
                         kind_r != RSC_KIND_STOP;
         o_gpio_rst <= in_rst && !release_now &&
                       kind_r != RSC_KIND_STOP;
         o_pd0_oe <= in_rst && !release_now && state_r != ST_PIN &&
                     !(state_r == ST_HOLD && hold_cnt_r >= hold_lim);
         o_vec_fetch <= release_now;
         o_dbg_rst_clr <= in_rst && i_dbg_rst_req;
      end
   end

   assign o_pd0_out = 1'b0;
   assign o_vec_hi_addr = RSC_VEC_HI_ADDR;
   assign o_vec_lo_addr = RSC_VEC_LO_ADDR;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_wdog_irq <= 1'b0;
      else
         o_wdog_irq <= i_wdog_timeout && !i_opt.wdog_rst_sel;
   end

   // ------------------------------------------------------------------
   // wishbone slave
   // ------------------------------------------------------------------
   logic [7:0] osc_r, wdog_r;
   logic [3:0] cause_r;
   logic bus_req, wr_en, rd_cause;

   assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr_en = bus_req && i_wb_we && i_wb_sel[0];
   assign rd_cause = bus_req && !i_wb_we && i_wb_adr == RSC_ADR_CAUSE;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_wb_ack <= 1'b0;
      else
         o_wb_ack <= bus_req;
   end

   // oscillator and watchdog control reload on either kind of reset
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || (in_rst && kind_r != RSC_KIND_NONE))
      begin
         osc_r <= RSC_OSC_RST;
         wdog_r <= RSC_WDOG_RST;
      end
      else if (wr_en)
      begin
         if (i_wb_adr == RSC_ADR_OSC)
            osc_r <= i_wb_dat[7:0];
         if (i_wb_adr == RSC_ADR_WDOG)
            wdog_r <= i_wb_dat[7:0];
      end
   end

   assign o_clk_sel = osc_r[RSC_POS_CSEL +: 2];
   assign o_wdog_ctrl = wdog_r;

   // a cause published in the same cycle as a clearing read survives
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         cause_r <= '0;
      else if (release_now)
         cause_r <= pend_r;
      else if (rd_cause)
         cause_r <= '0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_wb_dat <= '0;
      else if (bus_req && !i_wb_we)
      begin
         unique case (i_wb_adr)
            RSC_ADR_CAUSE: o_wb_dat <= {24'h0, cause_r, 4'h0};
            RSC_ADR_OSC: o_wb_dat <= {24'h0, osc_r};
            RSC_ADR_WDOG: o_wb_dat <= {24'h0, wdog_r};
            RSC_ADR_STAT: o_wb_dat <= {26'h0, kind_r, state_r, i_stop_mode,
                                       i_opt.xtal_en};
            default: o_wb_dat <= '0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_hold_done;
      state_r == ST_PIN && pd0_s && !por_req;
   endsequence

   sequence s_pin_low;
      state_r == ST_HOLD && hold_cnt_r >= hold_lim && !pd0_s && !por_req;
   endsequence

   hold_short_a: assert property (
      state_r == ST_HOLD && !i_opt.xtal_en && hold_cnt_r < 13'(HOLD_SHORT)
      |=> state_r != ST_PIN && state_r != ST_RUN)
      else $error("release before short hold ended");
   hold_long_a: assert property (
      state_r == ST_HOLD && i_opt.xtal_en && hold_cnt_r < 13'(HOLD_LONG)
      |=> state_r != ST_PIN && state_r != ST_RUN)
      else $error("crystal hold released early");
   pin_keep_a: assert property (
      s_pin_low |=> state_r == ST_PIN && o_core_rst)
      else $error("reset left while pin low");
   supply_wait_a: assert property (
      !por_s |=> state_r == ST_SUPPLY)
      else $error("count not held for low supply");
   release_vec_a: assert property (
      s_hold_done |=> o_vec_fetch ##1 !o_vec_fetch && !o_core_rst)
      else $error("vector fetch not issued at release");
   pd0_drive_a: assert property (
      $past(state_r) == ST_HOLD && state_r == ST_HOLD
      |-> o_pd0_oe && !o_pd0_out)
      else $error("pd0 not driven low in reset");
   stop_keep_a: assert property (
      state_r == ST_RUN && stop_req && !sys_req && !por_req
      |=> ##1 !o_periph_rst)
      else $error("stop recovery reset registers");
   short_pin_a: assert property (
      state_r == ST_RUN && !i_stop_mode && !por_req && !i_dbg_rst_req &&
      !i_wdog_timeout && !i_debug_pin_low && !smr_edge &&
      pin_low_cnt_r < 3'(RSC_PIN_MIN_CLKS) |=> state_r == ST_RUN)
      else $error("short pin pulse caused reset");
   wdog_irq_a: assert property (
      i_wdog_timeout && !i_opt.wdog_rst_sel |=> o_wdog_irq)
      else $error("watchdog interrupt missing");
   cause_clr_a: assert property (
      rd_cause && !release_now |=> cause_r == 4'h0)
      else $error("cause bits not cleared by read");
   osc_ipo_a: assert property (
      o_core_rst |-> o_clk_sel == RSC_CSEL_IPO)
      else $error("clock not on precision osc in reset");
endmodule : rsc_reset_ctrl
`default_nettype wire

// File: verification/rsc_core_model.sv
// far-side model: the core held in reset and the shared reset pin
`timescale 1ns/1ps
`default_nettype none
module rsc_core_model
#(
   parameter logic [15:0] VEC = 16'h0100     // vector contents, arbitrary
)(
   input wire logic i_clk,                   // system clock
   input wire logic i_core_rst,              // core held in reset
   input wire logic i_vec_fetch,             // vector fetch start
   input wire logic [15:0] i_vec_hi_addr,    // vector high byte addr
   input wire logic [15:0] i_vec_lo_addr,    // vector low byte addr
   input wire logic i_pd0_out,               // device pin level
   input wire logic i_pd0_oe,                // device pin drive enable
   input wire logic i_ext_low,               // outside party pulls low
   output logic o_pd0_wire,                  // resolved pin level
   output var logic [7:0] o_fetch_count = 8'h00, // good fetches
   output var logic [15:0] o_pc = 16'h0000   // program counter
);
   // pull-up wins unless somebody pulls the open-drain line low
   assign o_pd0_wire = !((i_pd0_oe && !i_pd0_out) || i_ext_low);
   always_ff @(posedge i_clk)
   begin
      if (i_core_rst)
         o_pc <= o_pc;
      else if (i_vec_fetch && i_vec_hi_addr === 16'h0002
               && i_vec_lo_addr === 16'h0003)
      begin
         o_fetch_count <= o_fetch_count + 8'h01;
         o_pc <= VEC;
      end
      else
         o_pc <= o_pc + 16'h0001;
   end
endmodule : rsc_core_model
`default_nettype wire

// File: verification/rsc_reset_ctrl_tb_top.sv
// self-checking bench for the reset and stop recovery controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
   err_count++; end end
module rsc_reset_ctrl_tb_top;
   import rsc_pkg::*;
   localparam int HS = 4;
   localparam int HL = 10;
   logic i_clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'hF;
   logic [31:0] wdat = 32'h0, o_wb_dat, seed = 32'h000022CE;
   logic [1:0] internal_precision_osc = 2'h0, o_clk_sel;
   logic por_ok = 1'b0, brn_n = 1'b1, ext_low = 1'b0, pd0_en = 1'b0;
   logic [7:0] gpio = 8'h00, smr = 8'h00, fetches, o_wdog_ctrl;
   logic stop = 1'b0, wdto = 1'b0, dbg_req = 1'b0, dbg_pin = 1'b0;
   rsc_opt_t opt = 3'b010;
   logic o_wb_ack, o_core_rst, o_periph_rst, o_gpio_rst, o_pd0_out;
   logic o_pd0_oe, o_dbg_rst_clr, o_wdog_irq, o_vec_fetch, pd0;
   logic [15:0] o_vec_hi_addr, o_vec_lo_addr;
   int err_count = 0, tests_run = 0, cycles = 0, held = 0;
   logic core_q = 1'b1, pin_wait = 1'b0;
   rsc_reset_ctrl #(.HOLD_SHORT(HS), .HOLD_LONG(HL)) u_rsc_reset_ctrl (
      .i_clk(i_clk), .i_sys_rst(sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ipo_clk(internal_precision_osc[1]),
      .i_por_ok(por_ok), .i_brownout_n(brn_n), .i_pd0_in(pd0),
      .i_gpio_in(gpio), .i_smr_en(smr), .i_pd0_rst_en(pd0_en),
      .i_stop_mode(stop), .i_wdog_timeout(wdto), .i_dbg_rst_req(dbg_req),
      .i_debug_pin_low(dbg_pin), .i_opt(opt), .o_core_rst(o_core_rst),
      .o_periph_rst(o_periph_rst), .o_gpio_rst(o_gpio_rst),
      .o_pd0_out(o_pd0_out), .o_pd0_oe(o_pd0_oe),
      .o_dbg_rst_clr(o_dbg_rst_clr), .o_wdog_irq(o_wdog_irq),
      .o_vec_fetch(o_vec_fetch), .o_vec_hi_addr(o_vec_hi_addr),
      .o_vec_lo_addr(o_vec_lo_addr), .o_clk_sel(o_clk_sel),
      .o_wdog_ctrl(o_wdog_ctrl));
   rsc_core_model u_rsc_core_model (
      .i_clk(i_clk), .i_core_rst(o_core_rst), .i_vec_fetch(o_vec_fetch),
      .i_vec_hi_addr(o_vec_hi_addr), .i_vec_lo_addr(o_vec_lo_addr),
      .i_pd0_out(o_pd0_out), .i_pd0_oe(o_pd0_oe), .i_ext_low(ext_low),
      .o_pd0_wire(pd0), .o_fetch_count(fetches), .o_pc());
   // ------------------------------------------------------------------
   // clock, precision osc (one rise every 4 clocks), hold meter, timeout
   // ------------------------------------------------------------------
   initial
   begin
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      internal_precision_osc <= internal_precision_osc + 2'h1;
      core_q <= o_core_rst;
      if (o_core_rst && !core_q)
         held <= 1;
      else if (o_core_rst)
         held <= held + 1;
      // the debugger drops its request once the device clears it
      if (o_dbg_rst_clr)
         dbg_req <= 1'b0;
      cycles++;
      if (cycles == 30000)
      begin
         err_count++;
         stop_test();
      end
   end
   // ------------------------------------------------------------------
   // bus, model and sequence helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_wb_ack !== 1'b1 && n < 20);
      q = o_wb_dat;
      if (n >= 20)
         err_count++;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, q);
      `CHK(q, {24'h0, e})
   endtask : rd_chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   // waits the reset out; hold of 0 skips the hold-length figure
   task automatic rel_chk(input int hold, input logic per,
                          input logic [7:0] cause, input string name);
      int n;
      logic [7:0] f0;
      n = 0;
      f0 = fetches;
      while (o_core_rst !== 1'b1 && n < 80)
      begin
         @(posedge i_clk);
         n++;
      end
      @(posedge i_clk);
      `CHK({o_core_rst, o_periph_rst, o_gpio_rst}, {1'b1, per, per})
      `CHK({o_pd0_oe, o_pd0_out}, {!pin_wait, 1'b0})
      n = 0;
      while (o_core_rst !== 1'b0 && n < 4000)
      begin
         @(posedge i_clk);
         n++;
      end
      if (hold > 0)
         `CHK(held >= hold * 4 - 4 && held <= hold * 4 + 16, 1'b1)
      repeat (3) @(posedge i_clk);
      `CHK(fetches, f0 + 8'h01)
      rd_chk(RSC_ADR_CAUSE, cause);
      rd_chk(RSC_ADR_OSC, RSC_OSC_RST);
      rd_chk(RSC_ADR_WDOG, RSC_WDOG_RST);
      `CHK(o_clk_sel, RSC_CSEL_IPO)
      $display("test %s done", name);
   endtask : rel_chk
   task automatic wd_pulse;
      @(posedge i_clk);
      wdto <= 1'b1;
      @(posedge i_clk);
      wdto <= 1'b0;
   endtask : wd_pulse
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge i_clk);
      sys_rst <= 1'b0;
      repeat (30) @(posedge i_clk);
      `CHK(o_core_rst, 1'b1)
      por_ok <= 1'b1;
      rel_chk(0, 1'b1, 8'h80, "power_on");
      rd_chk(RSC_ADR_CAUSE, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         wr(RSC_ADR_OSC, seed[7:0]);
         rd_chk(RSC_ADR_OSC, seed[7:0]);
         `CHK(o_clk_sel, seed[1:0])
      end
      wr(RSC_ADR_CAUSE, 8'hFF);
      rd_chk(RSC_ADR_CAUSE, 8'h00);
      rd_chk(4'h2, 8'h00);
      opt.wdog_rst_sel <= 1'b0;
      wd_pulse();
      @(posedge i_clk);
      `CHK(o_wdog_irq, 1'b1)
      repeat (12) @(posedge i_clk);
      `CHK(o_core_rst, 1'b0)
      opt.wdog_rst_sel <= 1'b1;
      wr(RSC_ADR_WDOG, 8'h5A);
      wd_pulse();
      rel_chk(HS, 1'b1, 8'h20, "watchdog");
      opt.xtal_en <= 1'b1;
      wd_pulse();
      rel_chk(HL, 1'b1, 8'h20, "crystal");
      opt.xtal_en <= 1'b0;
      @(posedge i_clk);
      dbg_req <= 1'b1;
      rel_chk(HS, 1'b1, 8'h80, "debugger");
      pd0_en <= 1'b1;
      ext_low <= 1'b1;
      repeat (2) @(posedge i_clk);
      ext_low <= 1'b0;
      repeat (12) @(posedge i_clk);
      `CHK(o_core_rst, 1'b0)
      ext_low <= 1'b1;
      repeat (150) @(posedge i_clk);
      `CHK(o_core_rst, 1'b1)
      ext_low <= 1'b0;
      pin_wait = 1'b1;
      rel_chk(0, 1'b1, 8'h10, "pin");
      pin_wait = 1'b0;
      smr <= 8'h01;
      gpio <= 8'h01;
      repeat (12) @(posedge i_clk);
      `CHK(o_core_rst, 1'b0)
      wr(RSC_ADR_OSC, 8'h03);
      wr(RSC_ADR_WDOG, 8'hA5);
      stop <= 1'b1;
      gpio <= 8'h00;
      rel_chk(HS, 1'b0, 8'h40, "stop_pin");
      wd_pulse();
      rel_chk(HS, 1'b0, 8'h60, "stop_watchdog");
      brn_n <= 1'b0;
      repeat (20) @(posedge i_clk);
      `CHK(o_core_rst, 1'b0)
      brn_n <= 1'b1;
      @(posedge i_clk);
      dbg_pin <= 1'b1;
      @(posedge i_clk);
      dbg_pin <= 1'b0;
      rel_chk(HS, 1'b1, 8'h80, "stop_debug_pin");
      stop <= 1'b0;
      brn_n <= 1'b0;
      por_ok <= 1'b0;
      repeat (100) @(posedge i_clk);
      `CHK(o_core_rst, 1'b1)
      brn_n <= 1'b1;
      por_ok <= 1'b1;
      rel_chk(0, 1'b1, 8'h80, "brownout");
      stop_test();
   end
endmodule : rsc_reset_ctrl_tb_top
`default_nettype wire
